//--- core/bitbang_cfg.svh
// timing and reset constants for the bit-bang parallel port
`ifndef BITBANG_CFG_SVH
`define BITBANG_CFG_SVH
`define BB_CLK_PERIOD_NS 4
`define BB_STROBE_NS 16
`define BB_SETTLE_CYCLES 4
`define BB_SYNC_DEPTH 3
`define BB_POWER_ENABLE_N_RST 1'b1
`define BB_STROBE_IDLE 1'b1
`endif

//--- core/bitbang_pkg.sv
// types shared by the bit-bang parallel port
package bitbang_pkg;
    typedef struct packed {
        logic valid;
        logic [7:0] dir;
        logic [7:0] data;
    } host_wr_s;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } host_rd_s;
    typedef enum logic [1:0] {ST_IDLE, ST_WSTB, ST_SETTLE, ST_RSTB} bb_state_e;
endpackage : bitbang_pkg

//--- core/bitbang_port.sv
// bit-bang parallel port for one channel, with send-now/wake handling
// How it works
// - in bit-bang mode the eight lines form one bidirectional 8-bit bus
// - synchronous and asynchronous variants; each channel instance chooses independently
// - write strobe pulses low when a new host value reaches the lines
// - read strobe rises when a sampled byte is forwarded to the host
// - suspended with wakeup enabled, a low wake strobe requests bus resume
// - powered, a low wake strobe flushes pending transmit data on next bulk-in
`timescale 1ns/100ps
`include "bitbang_cfg.svh"
module bitbang_port
    import bitbang_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int STROBE_NS = `BB_STROBE_NS,
    parameter int SETTLE_CYCLES = `BB_SETTLE_CYCLES
) (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_BB_ENABLE,
    input wire logic I_SYNC_MODE,
    input wire logic I_WAKE_ENABLE,
    input wire logic I_SUSPENDED,
    input wire logic I_SEND_NOW_WAKE_N,
    input wire host_wr_s I_HOST_WR,
    input wire logic I_HOST_RD_REQ,
    input wire logic [WIDTH-1:0] I_BUS_IN,
    output logic O_HOST_WR_READY,
    output host_rd_s O_HOST_RD,
    output logic [WIDTH-1:0] O_BUS_OUT,
    output logic [WIDTH-1:0] O_BUS_OE,
    output logic O_WRITE_STROBE_N,
    output logic O_READ_STROBE_N,
    output logic O_POWER_ENABLE_N,
    output logic O_RESUME_REQ,
    output logic O_SEND_NOW
);
    // least strobe time rounds up to whole cycles
    localparam int STROBE_CYC_I = (STROBE_NS + `BB_CLK_PERIOD_NS - 1) / `BB_CLK_PERIOD_NS;
    localparam int STROBE_CYC = (STROBE_CYC_I < 1) ? 1 : STROBE_CYC_I;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYC - 1);
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);

    bb_state_e state;
    bb_state_e next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [WIDTH-1:0] bus_s1, bus_s2, bus_s3, bus_stable;
    logic wake_s1, wake_s2, wake_s3, wake_level;
    logic [WIDTH-1:0] out_val, dir_val;

    // pin inputs: three stages, a bit changes only once stages two and three agree
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            bus_s1 <= '0;
            bus_s2 <= '0;
            bus_s3 <= '0;
            bus_stable <= '0;
        end else begin
            bus_s1 <= I_BUS_IN;
            bus_s2 <= bus_s1;
            bus_s3 <= bus_s2;
            bus_stable <= (bus_s2 & bus_s3) | (bus_stable & (bus_s2 ^ bus_s3));
        end
    end

    // wake pin resets high so a pin tied high never looks like a strobe
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            wake_s1 <= 1'b1;
            wake_s2 <= 1'b1;
            wake_s3 <= 1'b1;
            wake_level <= 1'b1;
        end else begin
            wake_s1 <= I_SEND_NOW_WAKE_N;
            wake_s2 <= wake_s1;
            wake_s3 <= wake_s2;
            wake_level <= (wake_s2 == wake_s3) ? wake_s3 : wake_level;
        end
    end

    // only a clean high-to-low change counts as a strobe
    wire wake_fall = wake_level && (wake_s2 == wake_s3) && !wake_s3;
    wire resume_hit = wake_fall && I_SUSPENDED && I_WAKE_ENABLE;
    wire flush_hit = wake_fall && !I_SUSPENDED;

    // handshake decode
    wire wr_take = (state == ST_IDLE) && I_BB_ENABLE && I_HOST_WR.valid;
    wire async_rd = (state == ST_IDLE) && I_BB_ENABLE && !I_SYNC_MODE && !I_HOST_WR.valid && I_HOST_RD_REQ;
    wire cnt_done = (cnt == '0);
    wire rd_done = (state == ST_RSTB) && cnt_done;

    // sequencer: write strobe, then in the synchronous variant settle and sample once
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        unique case (state)
            ST_IDLE: begin
                if (wr_take) begin
                    next_state = ST_WSTB;
                    next_cnt = STROBE_LAST;
                end else if (async_rd) begin
                    next_state = ST_RSTB;
                    next_cnt = STROBE_LAST;
                end
            end
            ST_WSTB: begin
                if (!cnt_done) begin
                    next_cnt = cnt - 1'b1;
                end else if (I_SYNC_MODE) begin
                    next_state = ST_SETTLE;
                    next_cnt = SETTLE_LAST;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_SETTLE: begin
                if (!cnt_done) begin
                    next_cnt = cnt - 1'b1;
                end else begin
                    next_state = ST_RSTB;
                    next_cnt = STROBE_LAST;
                end
            end
            ST_RSTB: begin
                if (!cnt_done) begin
                    next_cnt = cnt - 1'b1;
                end else begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            state <= ST_IDLE;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // applied value and direction; lines float whenever bit-bang is off
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            out_val <= '0;
            dir_val <= '0;
        end else if (wr_take) begin
            out_val <= I_HOST_WR.data;
            dir_val <= I_HOST_WR.dir;
        end
    end

    // pin and host outputs, all registered
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_BUS_OUT <= '0;
            O_BUS_OE <= '0;
            O_WRITE_STROBE_N <= `BB_STROBE_IDLE;
            O_READ_STROBE_N <= `BB_STROBE_IDLE;
            O_HOST_WR_READY <= 1'b0;
            O_HOST_RD <= '0;
        end else begin
            O_BUS_OUT <= wr_take ? I_HOST_WR.data : out_val;
            O_BUS_OE <= !I_BB_ENABLE ? '0 : (wr_take ? I_HOST_WR.dir : dir_val);
            O_WRITE_STROBE_N <= (next_state != ST_WSTB);
            O_READ_STROBE_N <= (next_state != ST_RSTB);
            O_HOST_WR_READY <= (next_state == ST_IDLE) && I_BB_ENABLE;
            O_HOST_RD.valid <= rd_done;
            O_HOST_RD.data <= rd_done ? bus_stable : O_HOST_RD.data;
        end
    end

    // suspend state and wake events; both events are one-cycle pulses
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_POWER_ENABLE_N <= `BB_POWER_ENABLE_N_RST;
            O_RESUME_REQ <= 1'b0;
            O_SEND_NOW <= 1'b0;
        end else begin
            O_POWER_ENABLE_N <= I_SUSPENDED;
            O_RESUME_REQ <= resume_hit;
            O_SEND_NOW <= flush_hit;
        end
    end

    // checks
    chk_wstb_width: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        $fell(O_WRITE_STROBE_N) |-> !O_WRITE_STROBE_N [*4] ##1 O_WRITE_STROBE_N)
        else $error("write strobe width wrong");
    chk_wstb_value: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        wr_take |=> !O_WRITE_STROBE_N && O_BUS_OUT == $past(I_HOST_WR.data))
        else $error("strobe without new value");
    chk_rstb_rise: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        $rose(O_READ_STROBE_N) |-> O_HOST_RD.valid)
        else $error("read strobe rise without data");
    chk_rd_valid: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        O_HOST_RD.valid |-> $rose(O_READ_STROBE_N))
        else $error("data without read strobe rise");
    chk_sync_sample: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (wr_take && I_SYNC_MODE) |-> ##[10:14] O_HOST_RD.valid)
        else $error("sync write returned no sample");
    chk_oe_off: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        !I_BB_ENABLE |=> O_BUS_OE == '0)
        else $error("bus driven while disabled");
    chk_resume_req: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        O_RESUME_REQ |-> $past(I_SUSPENDED) && $past(I_WAKE_ENABLE) && !$past(wake_s3))
        else $error("resume without suspended strobe");
    chk_flush_req: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        flush_hit |=> O_SEND_NOW && !O_RESUME_REQ)
        else $error("flush strobe lost");
    chk_async_one: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (wr_take && !I_SYNC_MODE) |-> ##[5:6] state == ST_IDLE)
        else $error("async write did not finish");
    cov_sync_cycle: cover property (@(posedge I_CLK) disable iff (I_SYS_RST)
        wr_take && I_SYNC_MODE ##[1:20] O_HOST_RD.valid);
    cov_async_read: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) async_rd);
    cov_resume: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) O_RESUME_REQ);
    cov_flush: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) O_SEND_NOW);
endmodule : bitbang_port

//--- verification/line_partner.sv
// outside circuitry on the eight lines and the wake pin
`timescale 1ns/100ps
module line_partner (
    input wire logic i_clk,
    input wire logic [7:0] i_bus_out,
    input wire logic [7:0] i_bus_oe,
    input wire logic [7:0] i_ext,
    input wire logic i_wake_go,
    output logic [7:0] o_bus_in,
    output logic o_wake_n
);
    int cnt = 0;
    // device wins where it drives, outside value elsewhere
    assign o_bus_in = (i_bus_oe & i_bus_out) | (~i_bus_oe & i_ext);
    // wake idles high, strobes low 6 cycles, then high again
    always @(posedge i_clk) begin
        cnt <= i_wake_go ? 12 : (cnt > 0 ? cnt - 1 : 0);
    end
    assign o_wake_n = !(cnt > 6);
endmodule : line_partner

//--- verification/tb_bitbang_port.sv
// self-checking bench for the bit-bang parallel port
`timescale 1ns/100ps
module tb_bitbang_port;
    import bitbang_pkg::*;
    logic clk = 0, rst = 1, en = 1, syn = 1, wen = 0, susp = 0, rreq = 0, wgo = 0;
    host_wr_s wr = '0;
    host_rd_s rd;
    logic [7:0] ext = 8'h00, bin, bout, boe, dir, dat, got;
    logic rdy, wstb_n, rstb_n, pwr_n, res, snd, wake_n;
    int errors = 0, n_checks = 0, cyc = 0, seed = 32'h0766, n_low, n_rd, n_res, n_snd;
    initial forever #2 clk = ~clk;
    bitbang_port u_bitbang_port (.I_CLK(clk), .I_SYS_RST(rst), .I_BB_ENABLE(en), .I_SYNC_MODE(syn),
        .I_WAKE_ENABLE(wen), .I_SUSPENDED(susp), .I_SEND_NOW_WAKE_N(wake_n), .I_HOST_WR(wr),
        .I_HOST_RD_REQ(rreq), .I_BUS_IN(bin), .O_HOST_WR_READY(rdy), .O_HOST_RD(rd), .O_BUS_OUT(bout),
        .O_BUS_OE(boe), .O_WRITE_STROBE_N(wstb_n), .O_READ_STROBE_N(rstb_n), .O_POWER_ENABLE_N(pwr_n),
        .O_RESUME_REQ(res), .O_SEND_NOW(snd));
    line_partner u_line_partner (.i_clk(clk), .i_bus_out(bout), .i_bus_oe(boe), .i_ext(ext),
        .i_wake_go(wgo), .o_bus_in(bin), .o_wake_n(wake_n));
    // level seen on each line: driven value or outside value
    function automatic logic [7:0] exp_line(logic [7:0] d, logic [7:0] v, logic [7:0] e);
        return (d & v) | (~d & e);
    endfunction : exp_line
    task automatic check(logic [7:0] g, logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check
    // single-bit outputs; an unknown never matches
    task automatic check_flag(logic g, logic e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check_flag
    // counts kept by the bench itself, so never unknown
    task automatic check_count(int g, int e);
        n_checks++;
        if (g != e) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check_count
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // count strobes and pulses over a span; called on an edge, so the cycle that edge launches counts too
    task automatic watch(int span);
        n_low = 0;
        n_rd = 0;
        n_res = 0;
        n_snd = 0;
        #1;
        repeat (span) begin
            n_low += (wstb_n === 1'b0);
            n_res += (res === 1'b1);
            n_snd += (snd === 1'b1);
            if (rd.valid === 1'b1) begin
                n_rd++;
                got = rd.data;
                check_flag(rstb_n, 1'b1);
            end
            @(posedge clk);
            #1;
        end
    endtask : watch
    // present one write once ready is seen; taken at the next edge
    task automatic host_write();
        for (int i = 0; i < 30 && rdy !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        wr <= '{1'b1, dir, dat};
        @(posedge clk);
        wr.valid <= 1'b0;
    endtask : host_write
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        #1;
        check(boe, 8'h00);
        check_flag(wstb_n, 1'b1);
        check_flag(rstb_n, 1'b1);
        check_flag(rd.valid, 1'b0);
        check_flag(pwr_n, 1'b1);
        @(posedge clk);
        rst <= 1'b0;
        // synchronous writes, all-in and all-out first, then random
        for (int i = 0; i < 14; i++) begin
            dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            dat = 8'($random(seed));
            @(posedge clk);
            ext <= 8'($random(seed));
            #1;
            host_write();
            watch(16);
            check_count(n_low, 4);
            check_count(n_rd, 1);
            check(got, exp_line(dir, dat, ext));
            check(boe, dir);
            check(bout, dat);
            check_flag(rdy, 1'b1);
        end
        $display("sync writes done");
        // asynchronous: a write brings no sample, a request does
        @(posedge clk);
        syn <= 1'b0;
        #1;
        dir = 8'($random(seed));
        dat = 8'($random(seed));
        host_write();
        watch(10);
        check_count(n_low, 4);
        check_count(n_rd, 0);
        @(posedge clk);
        rreq <= 1'b1;
        @(posedge clk);
        rreq <= 1'b0;
        watch(8);
        check_count(n_rd, 1);
        check(got, exp_line(dir, dat, ext));
        $display("async done");
        // bit-bang off: lines float, no strobes, no ready; the last direction returns on enable
        @(posedge clk);
        en <= 1'b0;
        watch(6);
        check(boe, 8'h00);
        check_flag(rdy, 1'b0);
        check_count(n_low + n_rd, 0);
        @(posedge clk);
        en <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(boe, dir);
        check_flag(rdy, 1'b1);
        $display("disable done");
        // wake strobe: resume, flush, and refused when wakeup is off
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            susp <= (k != 1);
            wen <= (k == 0);
            repeat (3) @(posedge clk);
            #1;
            check_flag(pwr_n, k != 1);
            @(posedge clk);
            wgo <= 1'b1;
            @(posedge clk);
            wgo <= 1'b0;
            watch(20);
            check_count(n_res, (k == 0) ? 1 : 0);
            check_count(n_snd, (k == 1) ? 1 : 0);
        end
        $display("wake done");
        tally_and_finish();
    end
endmodule : tb_bitbang_port
